/* File: common/fcal_cfg.svh */
// Offsets, field positions, reset values and timing counts of the audio link
`ifndef FCAL_CFG_SVH
`define FCAL_CFG_SVH

`define FCAL_OFS_CTRL 5'h00
`define FCAL_OFS_STATUS 5'h04
`define FCAL_OFS_IRQ_STAT 5'h08
`define FCAL_OFS_IRQ_MASK 5'h0c

`define FCAL_CTRL_RST 8'h00
`define FCAL_MASK_RST 4'h0
`define FCAL_PIN_RST 5'h18
`define FCAL_B_EN 0
`define FCAL_B_TDM 1
`define FCAL_B_RATE 2
`define FCAL_B_LANE2 4
`define FCAL_B_MCLK 5

`define FCAL_I_UNDER 0
`define FCAL_I_FAULT 1
`define FCAL_I_WARN 2
`define FCAL_I_FRAME 3

`define FCAL_CLK_HZ 64'd100000000
`define FCAL_XTAL_HZ 64'd24576000
`define FCAL_XTAL_ALT_HZ 64'd22579200
`define FCAL_NCO_INC ((2 * `FCAL_XTAL_HZ << 32) / `FCAL_CLK_HZ)
`define FCAL_NCO_INC_ALT ((2 * `FCAL_XTAL_ALT_HZ << 32) / `FCAL_CLK_HZ)

`define FCAL_DIV_FAST 4'd4
`define FCAL_DIV_SLOW 4'd8
`define FCAL_DIV_TDM 4'd1
`define FCAL_SAMPLE_BITS 5'd24
`define FCAL_I2S_LAST 9'd63
`define FCAL_TDM_LAST_FAST 9'd255
`define FCAL_TDM_LAST_SLOW 9'd511

`endif

/* File: common/fcal_pkg.sv */
// Types shared by the four-channel audio link
package fcal_pkg;

	typedef struct packed {
		logic [23:0] fl;
		logic [23:0] fr;
		logic [23:0] rl;
		logic [23:0] rr;
	} fcal_frame_t;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} fcal_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} fcal_avs_rsp_t;

	typedef enum logic [1:0] {
		FCAL_RATE_96K = 2'h0,
		FCAL_RATE_48K = 2'h1,
		FCAL_RATE_44K = 2'h2
	} fcal_rate_t;

endpackage : fcal_pkg

/* File: verilog/fcal_link.sv */
// Four-channel serial audio link master with clock buffer and amplifier pins
`timescale 1ns/1ns
`include "fcal_cfg.svh"

module fcal_link (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire fcal_pkg::fcal_avs_req_t avs_req,
	output fcal_pkg::fcal_avs_rsp_t avs_rsp,
	output logic irq,
	input wire fcal_pkg::fcal_frame_t frame_in,
	input wire logic frame_valid,
	output logic frame_ready,
	output logic bit_clock,
	output logic word_clock,
	output logic primary_data_lane,
	output logic secondary_data_lane,
	output logic multiply_select,
	output logic master_clock,
	input wire logic standby_request_low,
	input wire logic mute_request_low,
	input wire logic fault_cond,
	input wire logic clip_event,
	input wire logic overtemp_warn,
	output logic fault_flag_low_o,
	output logic fault_flag_low_oe,
	output logic warning_flag_low_o,
	output logic warning_flag_low_oe,
	output fcal_pkg::fcal_frame_t amp_drive,
	output logic amp_standby
);
	import fcal_pkg::*;

	// Serial bit for position pos of a slot, sent one bit late
	function automatic logic slot_bit(input logic [23:0] word, input logic [4:0] pos);
		logic [4:0] idx;
		idx = `FCAL_SAMPLE_BITS - pos;
		if (pos == 5'h00 || pos > `FCAL_SAMPLE_BITS)
			slot_bit = 1'b0;
		else
			slot_bit = word[idx];
	endfunction : slot_bit

	// Pin synchronisers
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Requests released, conditions clear: no false onset after reset
			pin_meta <= `FCAL_PIN_RST;
			pin_sync <= `FCAL_PIN_RST;
		end else begin
			pin_meta <= {standby_request_low, mute_request_low, fault_cond, clip_event, overtemp_warn};
			pin_sync <= pin_meta;
		end
	end

	wire standby_s = ~pin_sync[4];
	wire mute_s = ~pin_sync[3];
	wire fault_s = pin_sync[2];
	wire warn_s = pin_sync[1] | pin_sync[0];

	// Registers
	logic [7:0] ctrl;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic ack;
	logic [31:0] rdata;

	wire req = avs_req.read | avs_req.write;
	wire wr_hit = avs_req.write & ack;
	wire sel_ctrl = avs_req.address == `FCAL_OFS_CTRL;
	wire sel_stat = avs_req.address == `FCAL_OFS_STATUS;
	wire sel_istat = avs_req.address == `FCAL_OFS_IRQ_STAT;
	wire sel_imask = avs_req.address == `FCAL_OFS_IRQ_MASK;

	wire link_en = ctrl[`FCAL_B_EN];
	wire tdm = ctrl[`FCAL_B_TDM];
	wire lane2_en = ctrl[`FCAL_B_LANE2];
	wire mclk_en = ctrl[`FCAL_B_MCLK];
	wire fcal_rate_t rate = fcal_rate_t'(ctrl[`FCAL_B_RATE +: 2]);

	logic [3:0] irq_set;
	logic [31:0] status_word;
	logic [31:0] next_rdata;

	assign status_word = {27'h0, warn_s, fault_s, mute_s, standby_s, link_en};
	assign next_rdata = sel_ctrl ? {24'h0, ctrl} :
		sel_stat ? status_word :
		sel_istat ? {28'h0, irq_stat} :
		sel_imask ? {28'h0, irq_mask} : 32'h0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdata <= 32'h0;
		end else begin
			ack <= req & ~ack;
			rdata <= next_rdata;
		end
	end

	assign avs_rsp = '{readdata: rdata, waitrequest: req & ~ack};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `FCAL_CTRL_RST;
			irq_mask <= `FCAL_MASK_RST;
		end else if (wr_hit) begin
			if (sel_ctrl)
				ctrl <= avs_req.writedata[7:0];
			if (sel_imask)
				irq_mask <= avs_req.writedata[3:0];
		end
	end

	// Set wins over a same-cycle write-one clear
	wire [3:0] irq_clr = (wr_hit && sel_istat) ? avs_req.writedata[3:0] : 4'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			irq_stat <= 4'h0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	assign irq = |(irq_stat & irq_mask);

	// Crystal edge ticks from a phase accumulator; jitter is one ref_clk period
	logic [31:0] nco;
	logic tick;
	wire [31:0] nco_inc = (rate == FCAL_RATE_44K) ? 32'(`FCAL_NCO_INC_ALT) : 32'(`FCAL_NCO_INC);
	wire [32:0] nco_sum = {1'b0, nco} + {1'b0, nco_inc};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nco <= 32'h0;
			tick <= 1'b0;
		end else begin
			nco <= nco_sum[31:0];
			tick <= nco_sum[32];
		end
	end

	// Crystal ticks per bit clock half period
	logic [3:0] div_half;
	always_comb begin
		unique case (rate)
			FCAL_RATE_96K: div_half = `FCAL_DIV_FAST;
			FCAL_RATE_48K: div_half = `FCAL_DIV_SLOW;
			FCAL_RATE_44K: div_half = `FCAL_DIV_SLOW;
			default: div_half = `FCAL_DIV_FAST;
		endcase
		if (tdm)
			div_half = `FCAL_DIV_TDM;
	end

	logic [3:0] tcnt;
	wire half_done = tick && (tcnt == div_half - 4'd1);
	wire bclk_fall = half_done && bit_clock;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tcnt <= 4'h0;
			bit_clock <= 1'b0;
		end else if (!link_en) begin
			tcnt <= 4'h0;
			bit_clock <= 1'b0;
		end else if (tick) begin
			tcnt <= half_done ? 4'h0 : tcnt + 4'd1;
			if (half_done)
				bit_clock <= ~bit_clock;
		end
	end

	// Clock buffer: quadruple in two-channel mode, pass-through in TDM
	assign multiply_select = ~tdm;
	wire m4_hit = tick && (div_half == `FCAL_DIV_FAST || tcnt[0]);
	logic mclk_x4;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			mclk_x4 <= 1'b0;
		else if (!link_en)
			mclk_x4 <= 1'b0;
		else if (m4_hit)
			mclk_x4 <= ~mclk_x4;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			master_clock <= 1'b0;
		else if (!mclk_en)
			master_clock <= 1'b0;
		else
			master_clock <= multiply_select ? mclk_x4 : bit_clock;
	end

	// Bit position within the frame, advanced on falling bit clock
	logic [8:0] bpos;
	wire [8:0] frame_last = !tdm ? `FCAL_I2S_LAST :
		(rate == FCAL_RATE_96K) ? `FCAL_TDM_LAST_FAST : `FCAL_TDM_LAST_SLOW;
	wire wrap = bpos == frame_last;
	wire [8:0] next_bpos = wrap ? 9'h0 : bpos + 9'd1;
	wire frame_start = bclk_fall && wrap;

	// Frame taken as the new frame begins shifting
	assign frame_ready = frame_start;

	fcal_frame_t cur;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bpos <= 9'h0;
			cur <= '0;
		end else if (!link_en) begin
			bpos <= frame_last;
			cur <= '0;
		end else if (bclk_fall) begin
			bpos <= next_bpos;
			if (wrap)
				cur <= frame_valid ? frame_in : '0;
		end
	end

	// Lane contents for the coming bit
	wire [4:0] npos = next_bpos[4:0];
	wire right_half = next_bpos[5];
	wire [1:0] tdm_slot = next_bpos[6:5];
	wire fcal_frame_t nframe = wrap ? (frame_valid ? frame_in : '0) : cur;

	logic [23:0] word_a;
	logic [23:0] word_b;
	always_comb begin
		word_a = right_half ? nframe.fr : nframe.fl;
		word_b = right_half ? nframe.rr : nframe.rl;
		if (tdm) begin
			unique case (tdm_slot)
				2'h0: word_a = nframe.fl;
				2'h1: word_a = nframe.fr;
				2'h2: word_a = nframe.rl;
				2'h3: word_a = nframe.rr;
			endcase
			if (next_bpos[8:7] != 2'h0)
				word_a = 24'h0;
			word_b = 24'h0;
		end
	end

	wire next_wclk = tdm ? (next_bpos == 9'h0) : right_half;
	wire next_lane_a = slot_bit(word_a, npos);
	wire next_lane_b = lane2_en & slot_bit(word_b, npos);

	// All lane outputs change with the falling bit clock edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_clock <= 1'b0;
			primary_data_lane <= 1'b0;
			secondary_data_lane <= 1'b0;
		end else if (!link_en) begin
			word_clock <= 1'b0;
			primary_data_lane <= 1'b0;
			secondary_data_lane <= 1'b0;
		end else if (bclk_fall) begin
			word_clock <= next_wclk;
			primary_data_lane <= next_lane_a;
			secondary_data_lane <= next_lane_b;
		end
	end

	// Amplifier side: mute only zeroes the drive, the frame keeps updating
	wire silent = mute_s | standby_s;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_drive <= '0;
			amp_standby <= 1'b1;
		end else begin
			amp_standby <= standby_s;
			amp_drive <= silent ? '0 : cur;
		end
	end

	// Open-drain flags pull low while the condition holds
	assign fault_flag_low_o = 1'b0;
	assign warning_flag_low_o = 1'b0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_flag_low_oe <= 1'b0;
			warning_flag_low_oe <= 1'b0;
		end else begin
			fault_flag_low_oe <= fault_s;
			warning_flag_low_oe <= warn_s;
		end
	end

	// Events: underrun, fault and warning onset, frame start
	always_comb begin
		irq_set = 4'h0;
		irq_set[`FCAL_I_UNDER] = frame_start & ~frame_valid;
		irq_set[`FCAL_I_FAULT] = fault_s & ~fault_flag_low_oe;
		irq_set[`FCAL_I_WARN] = warn_s & ~warning_flag_low_oe;
		irq_set[`FCAL_I_FRAME] = frame_start;
	end

endmodule : fcal_link

/* File: testbench/fcal_link_chk.sv */
// Port checker for the audio link
`timescale 1ns/1ns
module fcal_link_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire fcal_pkg::fcal_avs_req_t avs_req,
	input wire fcal_pkg::fcal_avs_rsp_t avs_rsp,
	input wire logic frame_ready,
	input wire logic bit_clock,
	input wire logic word_clock,
	input wire logic primary_data_lane,
	input wire logic standby_request_low,
	input wire logic fault_cond,
	input wire logic clip_event,
	input wire logic overtemp_warn,
	input wire logic fault_flag_low_o,
	input wire logic fault_flag_low_oe,
	input wire logic warning_flag_low_oe,
	input wire fcal_pkg::fcal_frame_t amp_drive,
	input wire logic amp_standby
);
	import fcal_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire busy = avs_req.read | avs_req.write;
	one_wait_a: assert property (busy && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
		else $error("long wait");
	no_wait_a: assert property (!busy |-> !avs_rsp.waitrequest)
		else $error("idle wait");
	hole_zero_a: assert property (avs_req.read && !avs_rsp.waitrequest
		&& (avs_req.address[4] || avs_req.address[1:0] != 2'h0) |-> avs_rsp.readdata == 32'h0)
		else $error("hole read");
	lane_hold_a: assert property ($rose(bit_clock) |-> $stable(primary_data_lane) && $stable(word_clock))
		else $error("lane moved");
	frame_edge_a: assert property (frame_ready |-> bit_clock ##1 !bit_clock)
		else $error("frame edge");
	// Two sync stages plus the output register make three edges, so skip the first edges after reset
	fault_pin_a: assert property ($past(rst_n, 3) |-> fault_flag_low_oe == $past(fault_cond, 3) && !fault_flag_low_o)
		else $error("fault pin");
	warn_pin_a: assert property ($past(rst_n, 3) |-> warning_flag_low_oe == ($past(clip_event, 3) || $past(overtemp_warn, 3)))
		else $error("warn pin");
	stby_pin_a: assert property ($past(rst_n, 3) |-> amp_standby == !$past(standby_request_low, 3))
		else $error("standby pin");
	stby_quiet_a: assert property (amp_standby && $past(amp_standby) |-> amp_drive == '0)
		else $error("standby drive");
endmodule : fcal_link_chk

bind fcal_link fcal_link_chk fcal_link_chk_i (.ref_clk, .rst_n, .avs_req, .avs_rsp, .frame_ready, .bit_clock,
	.word_clock, .primary_data_lane, .standby_request_low, .fault_cond, .clip_event, .overtemp_warn,
	.fault_flag_low_o, .fault_flag_low_oe, .warning_flag_low_oe, .amp_drive, .amp_standby);

/* File: testbench/fcal_amp_model.sv */
// Amplifier receiver model: deserialises both lanes, resolves the flag lines
`timescale 1ns/1ns
module fcal_amp_model (
	input wire logic bit_clock,
	input wire logic word_clock,
	input wire logic pdl,
	input wire logic sdl,
	input wire logic fo,
	input wire logic foe,
	input wire logic wo,
	input wire logic woe,
	output fcal_pkg::fcal_frame_t rx_frame,
	output int rx_count,
	output logic fault_line_low,
	output logic warning_line_low
);
	import fcal_pkg::*;
	logic wc_q = 1'b0;
	int idx = 0;
	logic [23:0] sp;
	logic [23:0] ss;
	// Board pull-ups hold the lines high unless sunk
	assign fault_line_low = foe ? fo : 1'b1;
	assign warning_line_low = woe ? wo : 1'b1;
	// Sampled on the rise, where the lanes are settled
	always @(posedge bit_clock) begin
		idx = word_clock != wc_q ? 0 : idx + 1;
		wc_q = word_clock;
		if (idx >= 1 && idx <= 24) begin
			sp = {sp[22:0], pdl};
			ss = {ss[22:0], sdl};
		end
		if (idx == 24 && !word_clock) begin
			rx_frame.fl = sp;
			rx_frame.rl = ss;
		end
		if (idx == 24 && word_clock) begin
			rx_frame.fr = sp;
			rx_frame.rr = ss;
			rx_count++;
		end
	end
endmodule : fcal_amp_model

/* File: testbench/fcal_link_tb.sv */
// Self-checking bench for the audio link
`timescale 1ns/1ns
module fcal_link_tb;
	import fcal_pkg::*;
	localparam fcal_frame_t frm = 96'h9a5c31_6b13e7_c04f82_31d6a9;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	fcal_avs_req_t req = '0;
	fcal_avs_rsp_t rsp;
	fcal_frame_t frame_in = '0;
	fcal_frame_t amp_drive;
	fcal_frame_t rx;
	logic frame_valid = 1'b0;
	logic stby_n = 1'b1;
	logic mute_n = 1'b1;
	logic fault = 1'b0;
	logic clip = 1'b0;
	logic otw = 1'b0;
	logic irq, bit_clock, word_clock, master_clock, msel, pdl, sdl, fo, foe, wo, woe, stby, fl_n, wl_n;
	int rx_count;
	int num_errors = 0;
	int n_compared = 0;
	logic [31:0] q;
	fcal_link fcal_link_i (.ref_clk, .rst_n, .avs_req(req), .avs_rsp(rsp), .irq, .frame_in, .frame_valid,
		.frame_ready(), .bit_clock, .word_clock, .primary_data_lane(pdl), .secondary_data_lane(sdl),
		.multiply_select(msel), .master_clock, .standby_request_low(stby_n), .mute_request_low(mute_n),
		.fault_cond(fault), .clip_event(clip), .overtemp_warn(otw), .fault_flag_low_o(fo), .fault_flag_low_oe(foe),
		.warning_flag_low_o(wo), .warning_flag_low_oe(woe), .amp_drive, .amp_standby(stby));
	fcal_amp_model fcal_amp_model_i (.bit_clock, .word_clock, .pdl, .sdl, .fo, .foe, .wo, .woe, .rx_frame(rx),
		.rx_count, .fault_line_low(fl_n), .warning_line_low(wl_n));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task stop_test;
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [95:0] got, input logic [95:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask : chk
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		req <= '{address: a, read: !w, write: w, writedata: d};
		for (i = 0; i < 9; i++) begin
			@(posedge ref_clk);
			if (rsp.waitrequest === 1'b0)
				break;
		end
		q = rsp.readdata;
		req <= '0;
		@(posedge ref_clk);
		if (i == 9) begin
			num_errors++;
			stop_test();
		end
	endtask : bus
	task wfr(input int k);
		int i;
		k += rx_count;
		for (i = 0; i < 30000 && rx_count < k; i++)
			@(posedge ref_clk);
		if (rx_count < k) begin
			num_errors++;
			stop_test();
		end
	endtask : wfr
	// Rising edges of bit, master and word clocks over n cycles
	task cnt(input int n, output int b, output int m, output int w);
		logic [2:0] p;
		b = 0;
		m = 0;
		w = 0;
		p = {word_clock, master_clock, bit_clock};
		repeat (n) begin
			@(posedge ref_clk);
			b += bit_clock & !p[0];
			m += master_clock & !p[1];
			w += word_clock & !p[2];
			p = {word_clock, master_clock, bit_clock};
		end
	endtask : cnt
	task t_stream;
		bus(0, 5'h00, 32'h0);
		chk("ctrl", q, 32'h0);
		bus(0, 5'h08, 32'h0);
		chk("irq stat rst", q, 32'h0);
		bus(1, 5'h10, 32'hffffffff);
		bus(0, 5'h10, 32'h0);
		chk("hole", q, 32'h0);
		frame_in <= frm;
		frame_valid <= 1'b1;
		bus(1, 5'h00, 32'h31);
		wfr(3);
		chk("rx", rx, frm);
		chk("drive", amp_drive, frm);
		mute_n <= 1'b0;
		wfr(1);
		chk("muted", amp_drive, 96'h0);
		mute_n <= 1'b1;
		wfr(2);
		chk("unmuted", amp_drive, frm);
		stby_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("stby", stby, 1'b1);
		chk("stby drive", amp_drive, 96'h0);
		stby_n <= 1'b1;
		bus(1, 5'h00, 32'h21);
		wfr(2);
		chk("lane2 off", rx, {frm[95:48], 48'h0});
		frame_valid <= 1'b0;
		wfr(2);
		bus(0, 5'h08, 32'h0);
		chk("underrun", q[0], 1'b1);
	endtask : t_stream
	task t_rates;
		int r, b, m, w;
		int lo[3] = '{614, 307, 282};
		for (r = 0; r < 3; r++) begin
			bus(1, 5'h00, 32'h21 | (r << 2));
			repeat (300) @(posedge ref_clk);
			cnt(10000, b, m, w);
			chk("msel x4", msel, 1'b1);
			chk("bits", b inside {[lo[r]:lo[r] + 1]}, 1'b1);
			chk("words", w inside {[b / 64:b / 64 + 1]}, 1'b1);
			chk("mclk", (m + 2) / 4 inside {[lo[r]:lo[r] + 1]}, 1'b1);
		end
		bus(1, 5'h00, 32'h23);
		repeat (300) @(posedge ref_clk);
		cnt(1000, b, m, w);
		chk("msel", msel, 1'b0);
		chk("tdm bits", b inside {[245:246]}, 1'b1);
		chk("tdm mclk", m inside {[b - 1:b + 1]}, 1'b1);
		bus(1, 5'h00, 32'h01);
		cnt(1000, b, m, w);
		chk("mclk off", m, 96'h0);
	endtask : t_rates
	task t_irq;
		bus(1, 5'h0c, 32'h2);
		bus(1, 5'h08, 32'hf);
		fault <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("fault", {fl_n, irq}, 2'h1);
		bus(0, 5'h04, 32'h0);
		chk("stat", q[3], 1'b1);
		fault <= 1'b0;
		clip <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("clip", {fl_n, wl_n}, 2'h2);
		bus(1, 5'h08, 32'hf);
		chk("irq clr", irq, 1'b0);
		clip <= 1'b0;
		repeat (8) @(posedge ref_clk);
		otw <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("otw", wl_n, 1'b0);
		bus(1, 5'h0c, 32'h4);
		chk("irq warn", irq, 1'b1);
		otw <= 1'b0;
	endtask : t_irq
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_stream();
		t_rates();
		t_irq();
		stop_test();
	end
endmodule : fcal_link_tb
